// ### rtl/sba_arbiter.sv
// Central slot arbiter on the permanent master: grants backplane ownership
// Function
// - Slot request and acknowledge lines are low-true
// - Legacy masters may request via legacy line
// - Legacy masters change requests on clock edges
// - Acknowledges are clocked, after arbitration completes
// - Extended masters use only master pairs
// - Legacy masters never use master request line
// - Permanent master may grant shared bus request
// - Master and legacy pair counts are parameters
// - Per-slot enable selects board for configuration
// - Slot enable ignored for ordinary I/O decode
// - Shared request synchronised before use
// - Shared grant low-true, driven by owner
`timescale 1ns/1ps
module sba_arbiter #(
  parameter int NUM_MASTER = sba_pkg::NUM_MASTER_DEF,
  parameter int NUM_LEGACY = sba_pkg::NUM_LEGACY_DEF,
  parameter int NUM_SLOTS  = sba_pkg::NUM_SLOTS_DEF,
  localparam int NUM_REQ   = NUM_MASTER + NUM_LEGACY + 1,
  localparam int IDX_W     = $clog2(NUM_REQ),
  localparam int SLOT_W    = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Backplane
  sba_link_if.arbiter            link,
  // Shared request service
  input  wire logic              i_shared_enable,
  output logic                   o_shared_granted,
  // Slot configuration select
  input  wire logic              i_config_valid,
  input  wire logic [SLOT_W-1:0] i_config_slot,
  // Ownership status
  output logic                   o_busy,
  output logic                   o_owner_valid,
  output logic [IDX_W-1:0]       o_owner_index
);
  import sba_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int SHARED_IDX = NUM_REQ - 1;

  // Either set of pairs may be absent, but not both
  if (NUM_MASTER < 0 || NUM_LEGACY < 0 || NUM_MASTER + NUM_LEGACY < 1) begin : g_bad_pairs
    $error("arbiter needs at least one request pair");
  end
  if (NUM_MASTER > NUM_SLOTS || NUM_LEGACY > NUM_SLOTS) begin : g_bad_slots
    $error("more request pairs than slots");
  end

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Round robin: first pending requester at or after the start index
  function automatic logic [IDX_W-1:0] pick_next(input logic [NUM_REQ-1:0] req,
                                                 input logic [IDX_W-1:0]   start);
    int               idx;
    logic [IDX_W-1:0] found;
    logic             hit;
    idx   = 0;
    found = start;
    hit   = 1'b0;
    for (int i = 0; i < NUM_REQ; i++) begin
      idx = (int'(start) + i) % NUM_REQ;
      if (!hit && req[idx]) begin
        found = idx[IDX_W-1:0];
        hit   = 1'b1;
      end
    end
    return found;
  endfunction : pick_next

  function automatic logic [NUM_REQ-1:0] one_hot(input logic [IDX_W-1:0] idx);
    logic [NUM_REQ-1:0] v;
    v      = '0;
    v[idx] = 1'b1;
    return v;
  endfunction : one_hot

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] shared_sync;
  logic [SYNC_STAGES-1:0] next_shared_sync;
  logic [NUM_MASTER-1:0]  master_q;
  logic [NUM_MASTER-1:0]  next_master_q;
  logic [NUM_LEGACY-1:0]  legacy_q;
  logic [NUM_LEGACY-1:0]  next_legacy_q;
  logic [NUM_REQ-1:0]     req_vec;

  always_comb begin
    // Shared request may be asynchronous: two-stage synchroniser
    next_shared_sync = {shared_sync[SYNC_STAGES-2:0], link.shared_bus_request_n};
    // Slot lines are synchronous and low-true; stored active-high
    next_master_q    = ~link.slot_master_request_n;
    next_legacy_q    = ~link.slot_legacy_request_n;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      shared_sync <= '1;
      master_q    <= '0;
      legacy_q    <= '0;
    end else begin
      shared_sync <= next_shared_sync;
      master_q    <= next_master_q;
      legacy_q    <= next_legacy_q;
    end
  end

  // Shared request competes only while the permanent master agrees to serve it
  assign req_vec = {~shared_sync[SYNC_STAGES-1] & i_shared_enable, legacy_q, master_q};

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  sba_arb_state_t     state;
  sba_arb_state_t     next_state;
  logic [IDX_W-1:0]   owner;
  logic [IDX_W-1:0]   next_owner;
  logic [IDX_W-1:0]   ptr;
  logic [IDX_W-1:0]   next_ptr;
  logic [NUM_REQ-1:0] grant;
  logic [NUM_REQ-1:0] next_grant;

  always_comb begin
    next_state = state;
    next_owner = owner;
    next_ptr   = ptr;
    case (state)
      ARB_IDLE: begin
        if (|req_vec) begin
          next_state = ARB_DECIDE;
        end
      end
      ARB_DECIDE: begin
        // A full cycle to settle the choice before any acknowledge moves
        if (|req_vec) begin
          next_owner = pick_next(req_vec, ptr);
          next_state = ARB_GRANT;
        end else begin
          next_state = ARB_IDLE;
        end
      end
      ARB_GRANT: begin
        // Ownership stays until the owner lets go of its request, or for the shared request until i_shared_enable drops
        if (!req_vec[owner]) begin
          next_state = ARB_IDLE;
          if (owner == IDX_W'(SHARED_IDX)) begin
            next_ptr = '0;
          end else begin
            next_ptr = owner + IDX_W'(1);
          end
        end
      end
      default: next_state = ARB_IDLE;
    endcase
    // Single registered one-hot grant, so acknowledges never overlap
    next_grant = (next_state == ARB_GRANT) ? one_hot(next_owner) : '0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ARB_IDLE;
      owner <= '0;
      ptr   <= '0;
      grant <= '0;
    end else begin
      state <= next_state;
      owner <= next_owner;
      ptr   <= next_ptr;
      grant <= next_grant;
    end
  end

  // ----------------------------------------------------------------
  // Slot configuration enables
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] cfg_en;
  logic [NUM_SLOTS-1:0] next_cfg_en;

  always_comb begin
    next_cfg_en = '0;
    // Out-of-range slot numbers select no board
    if (i_config_valid && int'(i_config_slot) < NUM_SLOTS) begin
      next_cfg_en[i_config_slot] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_en <= '0;
    end else begin
      cfg_en <= next_cfg_en;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.slot_master_grant_n  = ~grant[NUM_MASTER-1:0];
  assign link.slot_legacy_grant_n  = ~grant[NUM_MASTER +: NUM_LEGACY];
  // Permanent master owns the line and drives it both ways, never floating
  assign link.shared_bus_grant_n   = ~grant[SHARED_IDX];
  assign link.slot_config_enable_n = ~cfg_en;

  assign o_shared_granted = grant[SHARED_IDX];
  assign o_busy           = (state != ARB_IDLE);
  assign o_owner_valid    = (state == ARB_GRANT);
  assign o_owner_index    = owner;

endmodule : sba_arbiter

// ### rtl/sba_pkg.sv
// Shared constants and state types for the slot bus arbiter and its slot agents
package sba_pkg;

  // ----------------------------------------------------------------
  // Default sizes
  // ----------------------------------------------------------------
  localparam int NUM_MASTER_DEF = 4;
  localparam int NUM_LEGACY_DEF = 4;
  localparam int NUM_SLOTS_DEF  = 4;
  localparam int SYNC_STAGES    = 2;

  // ----------------------------------------------------------------
  // Line levels
  // ----------------------------------------------------------------
  localparam logic LINE_IDLE   = 1'b1;
  localparam logic LINE_ACTIVE = 1'b0;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_DECIDE,
    ARB_GRANT
  } sba_arb_state_t;

  typedef enum logic [1:0] {
    AGT_IDLE,
    AGT_REQUEST,
    AGT_OWN,
    AGT_RELEASE
  } sba_agt_state_t;

endpackage : sba_pkg

// ### rtl/sba_link_if.sv
// Backplane arbitration lines between the slot arbiter and the slot agents
`timescale 1ns/1ps
interface sba_link_if #(
  parameter int NUM_MASTER = sba_pkg::NUM_MASTER_DEF,
  parameter int NUM_LEGACY = sba_pkg::NUM_LEGACY_DEF,
  parameter int NUM_SLOTS  = sba_pkg::NUM_SLOTS_DEF
) ();

  // ----------------------------------------------------------------
  // Per-slot pairs, all low-true
  // ----------------------------------------------------------------
  wire [NUM_MASTER-1:0] slot_master_request_n;
  wire [NUM_MASTER-1:0] slot_master_grant_n;
  wire [NUM_LEGACY-1:0] slot_legacy_request_n;
  wire [NUM_LEGACY-1:0] slot_legacy_grant_n;
  wire [NUM_SLOTS-1:0]  slot_config_enable_n;

  // ----------------------------------------------------------------
  // Shared open-collector request and totem-pole grant
  // ----------------------------------------------------------------
  wire [NUM_SLOTS-1:0]  shared_req_out;
  wire [NUM_SLOTS-1:0]  shared_req_oe;
  wire                  shared_bus_request_n;
  wire                  shared_bus_grant_n;

  // Wired level: any enabled driver showing low pulls the line low
  assign shared_bus_request_n = &(~shared_req_oe | shared_req_out);

  modport arbiter (
    input  slot_master_request_n,
    input  slot_legacy_request_n,
    input  shared_bus_request_n,
    output slot_master_grant_n,
    output slot_legacy_grant_n,
    output shared_bus_grant_n,
    output slot_config_enable_n
  );

  modport agent (
    output slot_master_request_n,
    output slot_legacy_request_n,
    output shared_req_out,
    output shared_req_oe,
    input  shared_bus_request_n,
    input  slot_master_grant_n,
    input  slot_legacy_grant_n,
    input  shared_bus_grant_n,
    input  slot_config_enable_n
  );

endinterface : sba_link_if

// ### rtl/sba_agent.sv
// Slot-side bus master agent: requests the backplane, owns it, releases it
`timescale 1ns/1ps
module sba_agent #(
  parameter int NUM_MASTER = sba_pkg::NUM_MASTER_DEF,
  parameter int NUM_LEGACY = sba_pkg::NUM_LEGACY_DEF,
  parameter int NUM_SLOTS  = sba_pkg::NUM_SLOTS_DEF,
  parameter int SLOT       = 0,
  parameter bit EXTENDED   = 1'b1,
  parameter bit USE_SHARED = 1'b0
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Backplane
  sba_link_if.agent link,
  // User side
  input  wire logic i_want_bus,
  input  wire logic i_config_cycle,
  output logic      o_owned,
  output logic      o_waiting,
  output logic      o_config_selected
);
  import sba_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (SLOT < 0 || SLOT >= NUM_SLOTS) begin : g_bad_slot
    $error("slot index outside slot count");
  end
  if (EXTENDED && SLOT >= NUM_MASTER) begin : g_bad_ext
    $error("extended agent needs a master pair on its slot");
  end
  if (!EXTENDED && !USE_SHARED && SLOT >= NUM_LEGACY) begin : g_bad_leg
    $error("legacy agent needs a legacy pair on its slot");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sba_agt_state_t state;
  sba_agt_state_t next_state;
  logic           req;
  logic           next_req;
  logic           cfg_sel;
  logic           next_cfg_sel;
  logic           granted;

  // Grant seen on whichever pair this architecture may use
  if (EXTENDED) begin : g_ext_grant
    assign granted = ~link.slot_master_grant_n[SLOT];
  end else if (USE_SHARED) begin : g_shr_grant
    // Limitation: the shared grant is common, so only one agent per system may use it
    assign granted = ~link.shared_bus_grant_n;
  end else begin : g_leg_grant
    assign granted = ~link.slot_legacy_grant_n[SLOT];
  end

  always_comb begin
    next_state   = state;
    next_req     = 1'b0;
    // Slot enable qualifies only configuration cycles, never ordinary I/O
    next_cfg_sel = i_config_cycle & ~link.slot_config_enable_n[SLOT];
    case (state)
      AGT_IDLE: begin
        if (i_want_bus) begin
          next_state = AGT_REQUEST;
        end
      end
      AGT_REQUEST: begin
        if (!i_want_bus) begin
          next_state = AGT_RELEASE;
        end else if (granted) begin
          next_state = AGT_OWN;
        end
      end
      AGT_OWN: begin
        if (!i_want_bus) begin
          next_state = AGT_RELEASE;
        end
      end
      AGT_RELEASE: begin
        // Wait for the grant to drop so a stale grant is never taken as a new one
        if (!granted) begin
          next_state = AGT_IDLE;
        end
      end
      default: next_state = AGT_IDLE;
    endcase
    // Request changes only on the clock edge, from a flip-flop
    next_req = (next_state == AGT_REQUEST) || (next_state == AGT_OWN);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state   <= AGT_IDLE;
      req     <= 1'b0;
      cfg_sel <= 1'b0;
    end else begin
      state   <= next_state;
      req     <= next_req;
      cfg_sel <= next_cfg_sel;
    end
  end

  // ----------------------------------------------------------------
  // Backplane drive
  // ----------------------------------------------------------------
  if (EXTENDED) begin : g_ext_pins
    assign link.slot_master_request_n[SLOT] = ~req;
    if (SLOT < NUM_LEGACY) begin : g_leg_idle
      assign link.slot_legacy_request_n[SLOT] = LINE_IDLE;
    end
  end else begin : g_leg_pins
    if (SLOT < NUM_MASTER) begin : g_mst_idle
      assign link.slot_master_request_n[SLOT] = LINE_IDLE;
    end
    if (SLOT < NUM_LEGACY) begin : g_leg_req
      assign link.slot_legacy_request_n[SLOT] = USE_SHARED ? LINE_IDLE : ~req;
    end
  end

  // Open collector: output always low, enable while requesting on a shared, non-extended agent
  assign link.shared_req_out[SLOT] = LINE_ACTIVE;
  assign link.shared_req_oe[SLOT]  = req & USE_SHARED & ~EXTENDED;

  // ----------------------------------------------------------------
  // User side
  // ----------------------------------------------------------------
  assign o_owned           = (state == AGT_OWN);
  assign o_waiting         = (state == AGT_REQUEST);
  assign o_config_selected = cfg_sel;

endmodule : sba_agent

// ### dv/sba_chk.sv
// Concurrent checks on the backplane arbitration lines
`timescale 1ns/1ps
module sba_chk
  import sba_pkg::*;
#(
  parameter int NUM_MASTER = NUM_MASTER_DEF,
  parameter int NUM_LEGACY = NUM_LEGACY_DEF,
  parameter int NUM_SLOTS  = NUM_SLOTS_DEF
) (
  // Clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  // Backplane lines
  input wire logic [NUM_MASTER-1:0] slot_master_request_n,
  input wire logic [NUM_MASTER-1:0] slot_master_grant_n,
  input wire logic [NUM_LEGACY-1:0] slot_legacy_request_n,
  input wire logic [NUM_LEGACY-1:0] slot_legacy_grant_n,
  input wire logic [NUM_SLOTS-1:0]  slot_config_enable_n,
  input wire logic                  shared_bus_request_n,
  input wire logic                  shared_bus_grant_n
);
  localparam int NP = NUM_MASTER + NUM_LEGACY;

  wire logic [NP:0] req_all = {shared_bus_request_n, slot_legacy_request_n, slot_master_request_n};
  wire logic [NP:0] gnt_all = {shared_bus_grant_n, slot_legacy_grant_n, slot_master_grant_n};
  logic [2:0]       quiet;
  logic [2:0]       next_quiet;

  // ----------------------------------------------------------------
  // Quiet counter: seven idle samples flush the shared synchroniser
  // ----------------------------------------------------------------
  always_comb begin
    next_quiet = quiet;
    if (!(&req_all && &gnt_all)) begin
      next_quiet = 3'h0;
    end else if (quiet != 3'h7) begin
      next_quiet = quiet + 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    quiet <= i_rst_n ? next_quiet : 3'h0;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_one_grant: assert property ($onehot0(~gnt_all))
    else $error("More than one grant low");
  chk_grant_cause: assert property (!(|(~gnt_all[NP-1:0] & $past(gnt_all[NP-1:0]) & $past(req_all[NP-1:0], 3))))
    else $error("Grant without a request three samples back");
  chk_grant_hold: assert property (!(|(gnt_all[NP-1:0] & ~$past(gnt_all[NP-1:0]) & ~$past(req_all[NP-1:0], 2))))
    else $error("Grant dropped while its request was held");
  chk_grant_latency: assert property ((quiet == 3'h7 && req_all[NP] && $onehot(~req_all))
    ##1 $stable(req_all) [*2] |=> (gnt_all == $past(req_all, 3)))
    else $error("Lone request not granted on the third edge");
  chk_shared_sync: assert property ($fell(shared_bus_request_n) |-> shared_bus_grant_n [*4])
    else $error("Shared grant came before synchronisation");
  chk_reset_idle: assert property ($rose(i_rst_n) |-> (&gnt_all && &slot_config_enable_n))
    else $error("Lines not high after reset");
  chk_cfg_single: assert property ($onehot0(~slot_config_enable_n))
    else $error("Two slot enables low");
  chk_pair_split: assert property (!(|(~slot_master_request_n & ~slot_legacy_request_n)))
    else $error("Slot drives both request lines");
endmodule : sba_chk

// ### dv/slot_bus_arbiter_tb.sv
// Self-checking bench: arbiter and four slot agents on one backplane
`timescale 1ns/1ps
module slot_bus_arbiter_tb;
  logic       i_clk;
  logic       i_rst_n;
  logic       shared_en;
  logic       cfg_valid;
  logic [1:0] cfg_slot;
  logic [3:0] want;
  logic [3:0] cfg_cycle;
  logic       shared_granted;
  logic       busy;
  logic       owner_valid;
  logic [3:0] owner_index;
  logic [3:0] owned;
  logic [3:0] waiting;
  logic [3:0] cfg_sel;
  int         errors;
  int         checks_done;

  // Requesting slot beside the owner index it should earn
  localparam logic [7:0] ROWS [4] = '{8'h10, 8'h21, 8'h46, 8'h88};

  // ----------------------------------------------------------------
  // Backplane: slots 0-1 extended, slot 2 legacy, slot 3 shared
  // ----------------------------------------------------------------
  // Interface and checker take the package default sizes, which match the arbiter's
  sba_link_if i_sba_link_if ();

  sba_arbiter #(.NUM_MASTER(4), .NUM_LEGACY(4), .NUM_SLOTS(4)) i_sba_arbiter (
    .i_clk           (i_clk),
    .i_rst_n         (i_rst_n),
    .link            (i_sba_link_if),
    .i_shared_enable (shared_en),
    .o_shared_granted(shared_granted),
    .i_config_valid  (cfg_valid),
    .i_config_slot   (cfg_slot),
    .o_busy          (busy),
    .o_owner_valid   (owner_valid),
    .o_owner_index   (owner_index)
  );

  for (genvar g = 0; g < 4; g++) begin : g_agent
    sba_agent #(.SLOT(g), .EXTENDED(g < 2), .USE_SHARED(g == 3)) i_sba_agent (
      .i_clk            (i_clk),
      .i_rst_n          (i_rst_n),
      .link             (i_sba_link_if),
      .i_want_bus       (want[g]),
      .i_config_cycle   (cfg_cycle[g]),
      .o_owned          (owned[g]),
      .o_waiting        (waiting[g]),
      .o_config_selected(cfg_sel[g])
    );
  end

  sba_chk i_sba_chk (
    .i_clk                (i_clk),
    .i_rst_n              (i_rst_n),
    .slot_master_request_n(i_sba_link_if.slot_master_request_n),
    .slot_master_grant_n  (i_sba_link_if.slot_master_grant_n),
    .slot_legacy_request_n(i_sba_link_if.slot_legacy_request_n),
    .slot_legacy_grant_n  (i_sba_link_if.slot_legacy_grant_n),
    .slot_config_enable_n (i_sba_link_if.slot_config_enable_n),
    .shared_bus_request_n (i_sba_link_if.shared_bus_request_n),
    .shared_bus_grant_n   (i_sba_link_if.shared_bus_grant_n)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic wait_owned(input logic [3:0] mask);
    for (int n = 0; n < 40 && (owned & mask) !== mask; n++) begin
      @(negedge i_clk);
    end
  endtask : wait_owned

  task automatic release_all;
    @(posedge i_clk);
    want      <= 4'h0;
    cfg_cycle <= 4'h0;
    @(negedge i_clk);
    for (int n = 0; n < 40 && (busy !== 1'b0 || owned !== 4'h0); n++) begin
      @(negedge i_clk);
    end
    check(busy, 1'b0);
    check(cfg_sel, 4'h0);
    // Idle gap so the next lone request starts from a quiet backplane
    repeat (8) @(posedge i_clk);
  endtask : release_all

  always #50 i_clk = ~i_clk;

  // Whole run is a few hundred cycles; far past that means a hang
  initial begin
    repeat (3000) @(posedge i_clk);
    errors++;
    finish_test();
  end

  initial begin
    i_clk     = 1'b0;
    i_rst_n   = 1'b0;
    shared_en = 1'b1;
    cfg_valid = 1'b0;
    cfg_slot  = 2'h0;
    want      = 4'h0;
    cfg_cycle = 4'h0;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    check({busy, owner_valid, owned}, 6'h00);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      @(posedge i_clk);
      want      <= ROWS[r][7:4];
      cfg_valid <= 1'b1;
      cfg_slot  <= 2'(r);
      cfg_cycle <= 4'hF;
      wait_owned(ROWS[r][7:4]);
      check(owner_index, ROWS[r][3:0]);
      check({owner_valid, owned}, {1'b1, ROWS[r][7:4]});
      check(shared_granted, r == 3);
      check(cfg_sel, ROWS[r][7:4]);
      release_all();
    end
    // Two extended slots at once: round robin restarts at slot 0
    @(posedge i_clk);
    want <= 4'h3;
    wait_owned(4'h1);
    check({owned, waiting}, 8'h12);
    check(i_sba_link_if.slot_master_request_n, 4'hC);
    @(posedge i_clk);
    want <= 4'h2;
    wait_owned(4'h2);
    check(owner_index, 4'h1);
    release_all();
    // Shared request refused while disabled, then granted and revoked
    @(posedge i_clk);
    shared_en <= 1'b0;
    want      <= 4'h9;
    wait_owned(4'h1);
    @(posedge i_clk);
    want <= 4'h8;
    repeat (20) @(negedge i_clk);
    check({shared_granted, owned}, 5'h00);
    @(posedge i_clk);
    shared_en <= 1'b1;
    wait_owned(4'h8);
    check({shared_granted, owner_index}, 5'h18);
    @(posedge i_clk);
    shared_en <= 1'b0;
    for (int n = 0; n < 20 && shared_granted !== 1'b0; n++) begin
      @(negedge i_clk);
    end
    check(shared_granted, 1'b0);
    release_all();
    // Reset while a legacy slot owns the bus
    @(posedge i_clk);
    shared_en <= 1'b1;
    want      <= 4'h4;
    wait_owned(4'h4);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    check({owner_valid, owned}, 5'h00);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    wait_owned(4'h4);
    check(owner_index, 4'h6);
    release_all();
    finish_test();
  end
endmodule : slot_bus_arbiter_tb
